/* File: nrz_pkg.sv */
package nrz_pkg;
    // =========================================================
    // byte framing
    localparam int BYTE_BITS = 8;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
    localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
    localparam logic [BYTE_BITS-1:0] BYTE_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam int FIFO_DEPTH = 2;

    // =========================================================
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int BIT_PERIOD_NS = 200;
    // half bit period, rounded down so the rate never falls below nominal
    localparam int BIT_HALF_CYCLES = BIT_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int CLEAR_PULSE_NS = 50;
    // least pulse width, rounded up
    localparam int CLEAR_CYCLES = (CLEAR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 8;

    // =========================================================
    // host transmit sequencer
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SYNC,
        TX_SEND
    } tx_state_t;
endpackage

/* File: nrz_link_if.sv */
interface nrz_link_if;
    import nrz_pkg::*;
    logic bit_clk;
    logic nrz_data;
    logic sync_start;
    logic test_drive;
    logic test_oe;
    logic test_level;
    logic byte_flag_clear_n;
    logic output_enable;
    logic [BYTE_BITS-1:0] parallel_byte_out;
    logic flag_out;
    logic flag_oe;
    logic chain_out;
    logic chain_oe;
    logic shclk_out;
    logic shclk_oe;
    logic byte_ready_flag;
    logic chain_level;
    logic shift_clock_out;

    // pull-up on the test pin; floating three-state outputs read low here
    assign test_level = test_oe ? test_drive : 1'b1;
    assign byte_ready_flag = flag_oe ? flag_out : 1'b0;
    assign chain_level = chain_oe ? chain_out : 1'b0;
    assign shift_clock_out = shclk_oe ? shclk_out : 1'b0;

    modport dev (
        input bit_clk,
        input nrz_data,
        input sync_start,
        input test_level,
        input byte_flag_clear_n,
        input output_enable,
        output parallel_byte_out,
        output flag_out,
        output flag_oe,
        output chain_out,
        output chain_oe,
        output shclk_out,
        output shclk_oe
    );

    modport host (
        output bit_clk,
        output nrz_data,
        output sync_start,
        output test_drive,
        output test_oe,
        output byte_flag_clear_n,
        output output_enable,
        input parallel_byte_out,
        input byte_ready_flag,
        input chain_level,
        input shift_clock_out
    );
endinterface

/* File: nrz_byte_deserializer.sv */
// Overview of operation
// R01: shift input bit on bit clock rise
// R02: sync start holds bit counter cleared
// R03: sync start sampled per full bit cycle
// R04: driver raises sync start before first bit
// R05: driver drops sync start in clock low
// R06: falling bit clock edge advances counter
// R07: eighth falling edge sets byte-ready flag
// R08: same edge loads parallel holding register
// R09: holding register stable while next shifts
// R10: low clear holds flag reset, level-sensitive
// R11: host releases clear before next byte
// R12: clear never touches shifter or counter
// R13: last shift stage drives chain output
// R14: shift clock output is inverted bit clock
// R15: enable low floats flag, chain, shift clock
// R16: pulled-up test pin ORed into inhibit
// R17: host reads byte, strobes clear meanwhile
// R18: host strobes clear once after power-up
// R19: byte outputs always driven, first bit MSB
module nrz_byte_deserializer (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    nrz_link_if.dev link,
    output logic [nrz_pkg::BYTE_BITS-1:0] byte_count_o,
    output logic overrun_o,
    output logic syncing_o
);
    import nrz_pkg::*;

    // =========================================================
    // bit clock edge detection
    logic bclk_prev_r;
    logic bclk_rise;
    logic bclk_fall;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bclk_prev_r <= 1'b0;
        end else begin
            bclk_prev_r <= link.bit_clk;
        end
    end

    assign bclk_rise = link.bit_clk & ~bclk_prev_r;
    assign bclk_fall = ~link.bit_clk & bclk_prev_r;

    // =========================================================
    // counter inhibit
    logic inhibit;
    logic inhibit_r;

    // test pin is active low; its pull-up keeps it idle when left open
    assign inhibit = link.sync_start | ~link.test_level; // R16

    // taken only at a rising edge, so a whole bit cycle must pass first
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inhibit_r <= 1'b1;
        end else if (bclk_rise) begin
            inhibit_r <= inhibit; // R03
        end
    end

    // =========================================================
    // shift register
    logic [BYTE_BITS-1:0] shift_r;

    // first bit ends up in the top position
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_r <= BYTE_RESET;
        end else if (bclk_rise) begin
            shift_r <= {shift_r[BYTE_BITS-2:0], link.nrz_data}; // R01 R19
        end
    end

    // =========================================================
    // bit counter
    logic [CNT_W-1:0] bit_cnt_r;
    logic byte_done;

    // clear input deliberately absent here
    assign byte_done = bclk_fall & ~inhibit_r & (bit_cnt_r == CNT_LAST); // R07 R12

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_r <= CNT_RESET;
        end else if (bclk_fall) begin
            if (inhibit_r) begin
                bit_cnt_r <= CNT_RESET; // R02
            end else begin
                bit_cnt_r <= bit_cnt_r + 3'h1; // R06
            end
        end
    end

    // =========================================================
    // holding register
    logic [BYTE_BITS-1:0] hold_r;

    // only reloads on a completed byte, so a slow reader sees a steady value
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_r <= BYTE_RESET;
        end else if (byte_done) begin
            hold_r <= shift_r; // R08 R09
        end
    end

    assign link.parallel_byte_out = hold_r; // R19

    // =========================================================
    // byte-ready flag
    logic flag_r;

    // a low clear beats a completing byte: the level holds the latch reset
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_r <= FLAG_RESET;
        end else if (!link.byte_flag_clear_n) begin
            flag_r <= 1'b0; // R10
        end else if (byte_done) begin
            flag_r <= 1'b1; // R07
        end
    end

    // =========================================================
    // byte accounting
    logic [BYTE_BITS-1:0] byte_cnt_r;
    logic overrun_r;
    logic syncing_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            byte_cnt_r <= BYTE_RESET;
        end else if (byte_done) begin
            byte_cnt_r <= byte_cnt_r + 8'h01;
        end
    end

    // a byte landing on an unread one means the host fell behind
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overrun_r <= 1'b0;
        end else if (byte_done && flag_r && link.byte_flag_clear_n) begin
            overrun_r <= 1'b1;
        end else if (!link.byte_flag_clear_n) begin
            overrun_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            syncing_r <= 1'b1;
        end else begin
            syncing_r <= inhibit_r;
        end
    end

    assign byte_count_o = byte_cnt_r;
    assign overrun_o = overrun_r;
    assign syncing_o = syncing_r;

    // =========================================================
    // cascade outputs and three-state control
    logic shclk_r;
    logic oe_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shclk_r <= 1'b1;
        end else begin
            shclk_r <= ~link.bit_clk; // R14
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= link.output_enable; // R15
        end
    end

    assign link.chain_out = shift_r[BYTE_BITS-1]; // R13
    assign link.shclk_out = shclk_r;
    assign link.flag_out = flag_r;
    assign link.flag_oe = oe_r; // R15
    assign link.chain_oe = oe_r; // R15
    assign link.shclk_oe = oe_r; // R15
endmodule

/* File: nrz_byte_host.sv */
module nrz_byte_host #(
    parameter int HALF_CYCLES = nrz_pkg::BIT_HALF_CYCLES,
    parameter int CLR_CYCLES = nrz_pkg::CLEAR_CYCLES,
    parameter int WIDTH = nrz_pkg::BYTE_BITS,
    parameter int DEPTH = nrz_pkg::FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    nrz_link_if.host link,
    input wire logic [nrz_pkg::BYTE_BITS-1:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic out_enable_i,
    input wire logic test_inhibit_i,
    output logic [WIDTH-1:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i
);
    import nrz_pkg::*;

    // =========================================================
    // bit clock divider and pin flops
    logic [DIV_W-1:0] div_r;
    logic bclk_r;
    logic tick;
    logic en_r;
    logic tinh_r;

    assign tick = (div_r == DIV_W'(HALF_CYCLES - 1));

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_r <= '0;
            bclk_r <= 1'b0;
        end else if (tick) begin
            div_r <= '0;
            bclk_r <= ~bclk_r;
        end else begin
            div_r <= div_r + DIV_W'(1);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_r <= 1'b0;
            tinh_r <= 1'b0;
        end else begin
            en_r <= out_enable_i;
            tinh_r <= test_inhibit_i;
        end
    end

    assign link.bit_clk = bclk_r;
    assign link.output_enable = en_r;
    assign link.test_drive = 1'b0;
    // pin left floating unless an inhibit is wanted
    assign link.test_oe = tinh_r;

    // =========================================================
    // transmit sequencer: new bits leave on the falling bit clock edge
    tx_state_t st_r;
    logic [BYTE_BITS-1:0] tx_sh_r;
    logic [CNT_W-1:0] tx_cnt_r;
    logic sync_r;
    logic take_r;
    logic fall;
    logic rise;

    assign fall = tick & bclk_r;
    assign rise = tick & ~bclk_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= TX_IDLE;
            tx_sh_r <= BYTE_RESET;
            tx_cnt_r <= CNT_RESET;
            sync_r <= 1'b1;
            take_r <= 1'b0;
        end else begin
            take_r <= 1'b0;
            case (st_r)
                TX_IDLE: begin
                    sync_r <= 1'b1;
                    if (tx_valid_i && rise) begin
                        st_r <= TX_SYNC;
                    end
                end
                TX_SYNC: begin
                    // a full high cycle has been seen; drop start in the low phase
                    if (fall) begin
                        sync_r <= 1'b0; // R04 R05
                        tx_sh_r <= tx_data_i;
                        tx_cnt_r <= CNT_RESET;
                        take_r <= 1'b1;
                        st_r <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (fall) begin
                        tx_cnt_r <= tx_cnt_r + 3'h1;
                        tx_sh_r <= {tx_sh_r[BYTE_BITS-2:0], 1'b0};
                        if (tx_cnt_r == CNT_LAST) begin
                            if (tx_valid_i) begin
                                tx_sh_r <= tx_data_i;
                                take_r <= 1'b1;
                            end else begin
                                sync_r <= 1'b1;
                                st_r <= TX_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    st_r <= TX_IDLE;
                end
            endcase
        end
    end

    assign link.sync_start = sync_r;
    assign link.nrz_data = tx_sh_r[BYTE_BITS-1];
    assign tx_ready_o = take_r;

    // =========================================================
    // reader: strobe clear while capturing, stall when buffer is full
    logic [DIV_W-1:0] clr_cnt_r;
    logic push;
    logic pop;
    logic full;
    logic [$clog2(DEPTH+1)-1:0] cnt_r;
    logic [WIDTH-1:0] mem_r [DEPTH];

    assign full = (cnt_r == DEPTH[$clog2(DEPTH+1)-1:0]);
    assign pop = rx_valid_o & rx_ready_i;
    assign push = link.byte_ready_flag & (clr_cnt_r == '0) & (~full | pop); // R17

    // loaded at reset so the indeterminate flag is cleared once
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clr_cnt_r <= DIV_W'(CLR_CYCLES); // R18
        end else if (push) begin
            clr_cnt_r <= DIV_W'(CLR_CYCLES); // R17
        end else if (clr_cnt_r != '0) begin
            clr_cnt_r <= clr_cnt_r - DIV_W'(1); // R11
        end
    end

    logic clr_n_r;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clr_n_r <= 1'b0;
        end else begin
            clr_n_r <= ~(push | (clr_cnt_r > DIV_W'(1)));
        end
    end
    assign link.byte_flag_clear_n = clr_n_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + ($clog2(DEPTH+1))'(push) - ($clog2(DEPTH+1))'(pop);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge core_clk_i) begin
                if (pop) begin
                    if (push && (cnt_r == ($clog2(DEPTH+1))'(gi + 1))) begin
                        mem_r[gi] <= link.parallel_byte_out;
                    end else if (gi < DEPTH - 1) begin
                        mem_r[gi] <= mem_r[(gi < DEPTH - 1) ? gi + 1 : gi];
                    end
                end else if (push && (cnt_r == ($clog2(DEPTH+1))'(gi))) begin
                    mem_r[gi] <= link.parallel_byte_out;
                end
            end
        end
    endgenerate

    assign rx_data_o = mem_r[0];
    assign rx_valid_o = (cnt_r != '0);
endmodule

/* File: nrz_link_asserts.sv */
module nrz_link_asserts (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic bit_clk,
    input wire logic sync_start,
    input wire logic test_level,
    input wire logic byte_flag_clear_n,
    input wire logic output_enable,
    input wire logic [nrz_pkg::BYTE_BITS-1:0] parallel_byte_out,
    input wire logic flag_out,
    input wire logic flag_oe,
    input wire logic chain_out,
    input wire logic chain_oe,
    input wire logic shclk_out,
    input wire logic shclk_oe
);
    import nrz_pkg::*;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // =========================================================
    // fall two samples back: one edge to detect it, one to register the result
    sequence fall_seen_s;
        $past(bit_clk, 2) && !$past(bit_clk);
    endsequence

    // =========================================================
    // wire checks
    a_shclk_inverse: assert property (shclk_out == !$past(bit_clk))
        else $error("shift clock output not inverse of bit clock");
    a_oe_follows_en: assert property (
        flag_oe == $past(output_enable) && chain_oe == $past(output_enable)
        && shclk_oe == $past(output_enable))
        else $error("output enables do not follow enable input");
    a_clear_kills_flag: assert property (!byte_flag_clear_n |=> !flag_out)
        else $error("flag set while clear held low");
    a_flag_holds_set: assert property (flag_out && byte_flag_clear_n |=> flag_out)
        else $error("flag dropped without clear");
    a_flag_on_fall: assert property ($rose(flag_out) |-> fall_seen_s)
        else $error("flag rose away from a bit clock fall");
    a_byte_on_fall: assert property (!$stable(parallel_byte_out) |-> fall_seen_s)
        else $error("parallel byte changed away from a bit clock fall");
    a_chain_last_stage: assert property (
        !$stable(parallel_byte_out) |-> chain_out == parallel_byte_out[7])
        else $error("chain output is not the last shift stage");
    a_inhibit_blocks_byte: assert property (
        $rose(flag_out) |-> !$past(sync_start, 3) && $past(test_level, 3))
        else $error("byte completed while counter inhibited");
endmodule

/* File: tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import nrz_pkg::*;

    localparam int HALF = 2;
    logic clk;
    logic rst_n;
    logic [BYTE_BITS-1:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    logic out_enable;
    logic test_inhibit;
    logic [BYTE_BITS-1:0] rx_data;
    logic rx_valid;
    logic rx_ready;
    logic [BYTE_BITS-1:0] byte_count;
    logic overrun;
    logic syncing;
    logic [BYTE_BITS-1:0] got_q[$];
    int failures = 0;
    int n_compared = 0;

    nrz_link_if link_if();
    nrz_link_if probe_if();

    always #2.5 clk = ~clk;

    nrz_byte_deserializer nrz_byte_deserializer_i (.core_clk_i(clk), .rst_n_i(rst_n),
        .link(link_if.dev), .byte_count_o(byte_count), .overrun_o(overrun),
        .syncing_o(syncing));
    nrz_byte_host #(.HALF_CYCLES(HALF), .CLR_CYCLES(2)) nrz_byte_host_i (.core_clk_i(clk),
        .rst_n_i(rst_n), .link(link_if.host), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .out_enable_i(out_enable), .test_inhibit_i(test_inhibit),
        .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready));
    // second device driven by the bench so the host side can misbehave
    nrz_byte_deserializer nrz_byte_deserializer_fault_i (.core_clk_i(clk), .rst_n_i(rst_n),
        .link(probe_if.dev), .byte_count_o(), .overrun_o(), .syncing_o());
    nrz_link_asserts nrz_link_asserts_i (.core_clk_i(clk), .rst_n_i(rst_n),
        .bit_clk(link_if.bit_clk), .sync_start(link_if.sync_start),
        .test_level(link_if.test_level), .byte_flag_clear_n(link_if.byte_flag_clear_n),
        .output_enable(link_if.output_enable), .parallel_byte_out(link_if.parallel_byte_out),
        .flag_out(link_if.flag_out), .flag_oe(link_if.flag_oe), .chain_out(link_if.chain_out),
        .chain_oe(link_if.chain_oe), .shclk_out(link_if.shclk_out),
        .shclk_oe(link_if.shclk_oe));

    always @(posedge clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            got_q.push_back(rx_data);
        end
    end

    // =========================================================
    // helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic send(input logic [7:0] b[$]);
        int n;
        foreach (b[i]) begin
            tx_data <= b[i];
            tx_valid <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (tx_ready !== 1'b1 && n < 400);
            if (n >= 400) failures++;
        end
        tx_valid <= 1'b0;
    endtask

    task automatic expect_rx(input logic [7:0] e[$]);
        int n;
        n = 0;
        while (got_q.size() < e.size() && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) failures++;
        foreach (e[i]) begin
            if (got_q.size() > 0) chk("rx byte", e[i], got_q.pop_front());
        end
    endtask

    // data changes with the fall, so it is settled well before the rise
    task automatic probe_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            probe_if.bit_clk <= 1'b0;
            probe_if.nrz_data <= v[i];
            repeat (HALF) @(posedge clk);
            probe_if.bit_clk <= 1'b1;
            repeat (HALF) @(posedge clk);
        end
        probe_if.bit_clk <= 1'b0;
        probe_if.nrz_data <= ~v[0];
        repeat (4) @(posedge clk);
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #50000;
        failures++;
        wrap_up();
    end

    // =========================================================
    // main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        tx_data = 8'h00;
        tx_valid = 1'b0;
        out_enable = 1'b1;
        test_inhibit = 1'b0;
        rx_ready = 1'b1;
        probe_if.bit_clk = 1'b0;
        probe_if.nrz_data = 1'b0;
        probe_if.sync_start = 1'b1;
        probe_if.test_drive = 1'b0;
        probe_if.test_oe = 1'b0;
        probe_if.byte_flag_clear_n = 1'b0;
        probe_if.output_enable = 1'b1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        send('{8'hA5, 8'h3C, 8'h81});
        expect_rx('{8'hA5, 8'h3C, 8'h81});
        chk("byte count", 8'h03, byte_count);
        // stalled reader: two words buffered, third overwritten by fourth
        rx_ready <= 1'b0;
        send('{8'h11, 8'h22, 8'h33, 8'h44});
        repeat (40) @(posedge clk);
        chk("overrun", 8'h01, {7'h00, overrun});
        chk("held byte", 8'h44, link_if.parallel_byte_out);
        rx_ready <= 1'b1;
        expect_rx('{8'h11, 8'h22, 8'h44});
        out_enable <= 1'b0;
        repeat (4) @(posedge clk);
        chk("oe off", 8'h00, {5'h00, link_if.flag_oe, link_if.chain_oe, link_if.shclk_oe});
        send('{8'h96});
        repeat (40) @(posedge clk);
        chk("byte while off", 8'h96, link_if.parallel_byte_out);
        chk("no push while off", 8'h00, 8'(got_q.size()));
        out_enable <= 1'b1;
        expect_rx('{8'h96});
        chk("oe on", 8'h07, {5'h00, link_if.flag_oe, link_if.chain_oe, link_if.shclk_oe});
        test_inhibit <= 1'b1;
        repeat (4) @(posedge clk);
        chk("syncing", 8'h01, {7'h00, syncing});
        send('{8'h5A});
        repeat (40) @(posedge clk);
        chk("count inhibited", 8'h08, byte_count);
        test_inhibit <= 1'b0;
        send('{8'hE7});
        expect_rx('{8'hE7});
        chk("count resumed", 8'h09, byte_count);
        // clear held low across a whole byte on the second link
        probe_byte(8'h00);
        probe_if.sync_start <= 1'b0;
        probe_byte(8'hC3);
        chk("byte under clear", 8'hC3, probe_if.parallel_byte_out);
        chk("chain under clear", 8'h01, {7'h00, probe_if.chain_level});
        chk("flag under clear", 8'h00, {7'h00, probe_if.flag_out});
        probe_if.byte_flag_clear_n <= 1'b1;
        probe_byte(8'h5A);
        chk("next byte", 8'h5A, probe_if.parallel_byte_out);
        chk("chain level", 8'h00, {7'h00, probe_if.chain_level});
        chk("shift clock out", 8'h01, {7'h00, probe_if.shift_clock_out});
        chk("flag after clear", 8'h01, {7'h00, probe_if.byte_ready_flag});
        wrap_up();
    end
endmodule
